// ---- include/nvm_prot_pkg.sv ----
`default_nettype none
package nvm_prot_pkg;
	// Lock geometry of the smallest variant; other variants pick 32/16 lock
	// bits, 64/32 pages per region, 256/128 byte pages
	localparam int LOCK_BITS = 8;
	localparam int PAGES_PER_REGION = 32;
	localparam int PAGE_BYTES = 64;
	localparam int REGION_BYTES = PAGES_PER_REGION * PAGE_BYTES;
	localparam int PAGE_NUM_W = 8;
	localparam int REGION_SHIFT = $clog2(PAGES_PER_REGION);
	localparam int LOCK_IDX_W = $clog2(LOCK_BITS);
	localparam int CALIB_W = 8;
	localparam int GP_BITS = 2;
	localparam int GP_BROWNOUT_EN = 0;
	localparam int GP_BROWNOUT_RST = 1;
	// Reset values
	localparam logic [LOCK_BITS-1:0] LOCK_RESET = 8'h00;
	localparam logic [GP_BITS-1:0] GP_RESET = 2'h0;
	// Recovery strap hold time: 10 s at 200 MHz
	localparam longint CLK_HZ = 200000000;
	localparam longint RECOVERY_HOLD_S = 10;
	localparam longint RECOVERY_HOLD_CYC = RECOVERY_HOLD_S * CLK_HZ;
	localparam int RECOVERY_CNT_W = 32;

	// Controller commands
	typedef enum logic [3:0] {
		CMD_NONE = 4'h0,
		CMD_PAGE_PROGRAM = 4'h1,
		CMD_PAGE_ERASE = 4'h2,
		CMD_FULL_ERASE = 4'h3,
		CMD_SET_LOCK = 4'h4,
		CMD_CLEAR_LOCK = 4'h5,
		CMD_SET_SECURITY = 4'h6,
		CMD_SET_GP = 4'h7,
		CMD_CLEAR_GP = 4'h8
	} cmd_type;

	// Command request from software
	typedef struct packed {
		logic valid;
		cmd_type cmd;
		logic [PAGE_NUM_W-1:0] page;
	} cmd_req_type;

	// Command outcome
	typedef struct packed {
		logic done;
		logic go;
		logic aborted;
	} cmd_rsp_type;
endpackage
`default_nettype wire

// ---- logic/pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for a group of pin levels
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [WIDTH-1:0] i_pin,
	output logic [WIDTH-1:0] o_level
);
	logic [WIDTH-1:0] meta_r;

	// First stage only feeds the second
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			meta_r <= '0;
			o_level <= '0;
		end
		else
		begin
			meta_r <= i_pin;
			o_level <= meta_r;
		end
	end
endmodule // pin_sync
`default_nettype wire

// ---- logic/hold_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
// Pulses once when a level has stood for HOLD_CYC cycles without a break
module hold_timer #(
	parameter longint HOLD_CYC = 2000000000
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_level,
	output logic o_expired
);
	import nvm_prot_pkg::*;
	logic [RECOVERY_CNT_W-1:0] cnt_r;
	logic [RECOVERY_CNT_W-1:0] cnt_nxt;
	logic fired_r;
	wire logic hit;

	assign hit = (cnt_r == RECOVERY_CNT_W'(HOLD_CYC - 1));
	assign cnt_nxt = i_level && !hit ? cnt_r + 1'b1 : (i_level ? cnt_r : '0);

	// Fires once per hold; a released level rearms the timer
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			cnt_r <= '0;
			fired_r <= 1'b0;
			o_expired <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			fired_r <= i_level && hit;
			o_expired <= i_level && hit && !fired_r;
		end
	end
endmodule // hold_timer
`default_nettype wire

// ---- logic/flash_protect.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_protect
	import nvm_prot_pkg::*;
#(
	parameter longint RECOVERY_CYC = nvm_prot_pkg::RECOVERY_HOLD_CYC,
	parameter logic [7:0] CALIB_VALUE = 8'h5a // Arbitrary factory value
) (
	input wire logic i_clk,
	input wire logic i_rst,
	// Software command port of the flash controller unit
	input wire nvm_prot_pkg::cmd_req_type i_cmd,
	output nvm_prot_pkg::cmd_rsp_type o_rsp,
	// Flash mode register field and status register flag
	input wire logic i_lock_err_irq_en,
	input wire logic i_lock_err_clear,
	output logic o_lock_error_flag,
	output logic o_irq,
	// External pins
	input wire logic i_erase_pin,
	input wire logic i_test_mode_pin,
	input wire logic i_port_line_0,
	input wire logic i_port_line_1,
	input wire logic i_port_line_2,
	// Access requests from debug and fast programming port
	input wire logic i_debug_access,
	input wire logic i_fast_prog_access,
	input wire nvm_prot_pkg::cmd_type i_fast_prog_cmd,
	output logic o_debug_grant,
	output logic o_fast_prog_grant,
	// State outputs
	output logic [nvm_prot_pkg::LOCK_BITS-1:0] o_lock_bits,
	output logic o_security,
	output logic o_brownout_det_en,
	output logic o_brownout_rst_en,
	output logic [nvm_prot_pkg::CALIB_W-1:0] o_calib,
	output logic o_fast_prog_mode,
	output logic o_boot_recovery
);
	import nvm_prot_pkg::*;

	logic [LOCK_BITS-1:0] lock_r;
	logic [LOCK_BITS-1:0] lock_nxt;
	logic [GP_BITS-1:0] gp_r;
	logic [GP_BITS-1:0] gp_nxt;
	logic secure_r;
	logic secure_nxt;
	logic erase_seen_r;
	logic erase_seen_nxt;
	logic lock_err_r;
	logic [4:0] pins_s;
	wire logic erase_s;
	wire logic tst_s;
	wire logic pl0_s;
	wire logic pl1_s;
	wire logic pl2_s;
	wire logic recovery_level;
	wire logic [LOCK_IDX_W-1:0] region;
	wire logic is_write;
	wire logic locked_hit;
	wire logic fast_cmd_ok;

	// All pins cross two flops before use
	pin_sync #(
		.WIDTH(5)
	) u_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_pin({i_erase_pin, i_test_mode_pin, i_port_line_0,
			i_port_line_1, i_port_line_2}),
		.o_level(pins_s)
	);
	assign erase_s = pins_s[4];
	assign tst_s = pins_s[3];
	assign pl0_s = pins_s[2];
	assign pl1_s = pins_s[1];
	assign pl2_s = pins_s[0];

	// Strap decode for fast programming and recovery
	assign o_fast_prog_mode = tst_s && pl0_s && pl1_s && !pl2_s;
	assign recovery_level = tst_s && pl0_s && pl1_s && pl2_s;

	// Recovery needs the strap held unbroken; a power cycle must follow
	hold_timer #(
		.HOLD_CYC(RECOVERY_CYC)
	) u_recovery (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_level(recovery_level),
		.o_expired(o_boot_recovery)
	);

	// Region index is the upper page bits, a power-of-two divide
	assign region = LOCK_IDX_W'(i_cmd.page >> REGION_SHIFT);
	assign is_write = i_cmd.valid && (i_cmd.cmd == CMD_PAGE_PROGRAM ||
		i_cmd.cmd == CMD_PAGE_ERASE || i_cmd.cmd == CMD_FULL_ERASE);
	// A full erase is refused if any region is locked
	assign locked_hit = is_write && ((i_cmd.cmd == CMD_FULL_ERASE) ?
		|lock_r : lock_r[region]);

	// Fast port takes only its documented command set
	assign fast_cmd_ok = i_fast_prog_cmd inside {CMD_NONE,
		CMD_PAGE_PROGRAM, CMD_PAGE_ERASE, CMD_FULL_ERASE, CMD_SET_LOCK,
		CMD_CLEAR_LOCK, CMD_SET_SECURITY};
	assign o_debug_grant = i_debug_access && !secure_r;
	assign o_fast_prog_grant = i_fast_prog_access && o_fast_prog_mode &&
		fast_cmd_ok && !secure_r;

	// Next state of the non-volatile bits
	always_comb
	begin
		lock_nxt = lock_r;
		gp_nxt = gp_r;
		secure_nxt = secure_r;
		erase_seen_nxt = erase_seen_r;
		if (i_cmd.valid && !locked_hit)
		begin
			unique case (i_cmd.cmd)
				CMD_SET_LOCK: lock_nxt[region] = 1'b1;
				CMD_CLEAR_LOCK: lock_nxt[region] = 1'b0;
				CMD_SET_SECURITY: secure_nxt = 1'b1;
				CMD_SET_GP: gp_nxt[i_cmd.page[0]] = 1'b1;
				CMD_CLEAR_GP: gp_nxt[i_cmd.page[0]] = 1'b0;
				CMD_FULL_ERASE:
				begin
					if (erase_seen_r)
					begin
						secure_nxt = 1'b0;
						erase_seen_nxt = 1'b0;
					end
				end
				default:
				begin
				end
			endcase
		end
		// Erase pin wins over lock and general-bit commands in the same cycle; security commands still apply
		if (erase_s)
		begin
			lock_nxt = LOCK_RESET;
			gp_nxt = GP_RESET;
			erase_seen_nxt = 1'b1;
		end
	end

	// Stand-in for the NV cells; reset models a blank part
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			lock_r <= LOCK_RESET;
			gp_r <= GP_RESET;
			secure_r <= 1'b0;
			erase_seen_r <= 1'b0;
		end
		else
		begin
			lock_r <= lock_nxt;
			gp_r <= gp_nxt;
			secure_r <= secure_nxt;
			erase_seen_r <= erase_seen_nxt;
		end
	end

	// Lock error is sticky; a new error beats a clear
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			lock_err_r <= 1'b0;
			o_rsp <= '0;
		end
		else
		begin
			if (locked_hit)
				lock_err_r <= 1'b1;
			else if (i_lock_err_clear)
				lock_err_r <= 1'b0;
			o_rsp.done <= i_cmd.valid;
			o_rsp.go <= is_write && !locked_hit;
			o_rsp.aborted <= locked_hit;
		end
	end

	assign o_lock_error_flag = lock_err_r;
	assign o_irq = lock_err_r && i_lock_err_irq_en;
	assign o_lock_bits = lock_r;
	assign o_security = secure_r;
	assign o_brownout_det_en = gp_r[GP_BROWNOUT_EN];
	assign o_brownout_rst_en = gp_r[GP_BROWNOUT_RST];
	assign o_calib = CALIB_VALUE;
endmodule // flash_protect
`default_nettype wire

// ---- verification/flash_protect_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_protect_properties
	import nvm_prot_pkg::*;
#(
	parameter logic [7:0] CALIB_VALUE = 8'h5a
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire nvm_prot_pkg::cmd_req_type i_cmd,
	input wire nvm_prot_pkg::cmd_rsp_type o_rsp,
	input wire logic i_lock_err_irq_en,
	input wire logic i_erase_pin,
	input wire logic i_test_mode_pin,
	input wire logic i_port_line_0,
	input wire logic i_port_line_1,
	input wire logic i_port_line_2,
	input wire logic o_lock_error_flag,
	input wire logic o_irq,
	input wire logic o_debug_grant,
	input wire logic o_fast_prog_grant,
	input wire logic [7:0] o_lock_bits,
	input wire logic o_security,
	input wire logic o_brownout_det_en,
	input wire logic o_brownout_rst_en,
	input wire logic [7:0] o_calib,
	input wire logic o_fast_prog_mode,
	input wire logic o_boot_recovery
);
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	// Lock of the region the command page falls in
	wire logic sel_lock = o_lock_bits[i_cmd.page[7:5]];
	wire logic wr_cmd = i_cmd.valid && (i_cmd.cmd == CMD_PAGE_ERASE
		|| i_cmd.cmd == CMD_PAGE_PROGRAM);
	a_abort_locked: assert property (wr_cmd |=>
		o_rsp.aborted == $past(sel_lock) && o_lock_error_flag >= o_rsp.aborted)
		else $error("abort mismatch");
	a_lock_sets: assert property (i_cmd.valid &&
		i_cmd.cmd == CMD_SET_LOCK |=> o_lock_bits[$past(i_cmd.page[7:5])])
		else $error("lock not set");
	a_irq_gate: assert property (
		o_irq == (o_lock_error_flag && i_lock_err_irq_en))
		else $error("irq mismatch");
	a_sec_refuse: assert property (
		o_security |-> !o_debug_grant && !o_fast_prog_grant)
		else $error("grant while secured");
	a_sec_rise: assert property ($rose(o_security) |->
		$past(i_cmd.valid) && $past(i_cmd.cmd) == CMD_SET_SECURITY)
		else $error("security set without command");
	a_gp_rise: assert property ($rose(o_brownout_det_en) |->
		$past(i_cmd.valid) && $past(i_cmd.cmd) == CMD_SET_GP)
		else $error("gp bit set without command");
	a_erase_clears: assert property (i_erase_pin[*4] |->
		o_lock_bits == 8'h00 && !o_brownout_det_en && !o_brownout_rst_en)
		else $error("erase pin did not clear");
	a_calib_fixed: assert property (o_calib == CALIB_VALUE)
		else $error("calibration changed");
	a_fast_mode: assert property (o_fast_prog_mode ==
		($past(i_test_mode_pin, 2) && $past(i_port_line_0, 2) &&
		$past(i_port_line_1, 2) && !$past(i_port_line_2, 2)))
		else $error("fast mode mismatch");
	// Main scenarios reached
	cover property (wr_cmd && sel_lock);
	cover property ($rose(o_security));
	cover property (o_boot_recovery);
endmodule // flash_protect_properties
`default_nettype wire

// ---- verification/test_flash_protect.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_flash_protect;
	import nvm_prot_pkg::*;
	logic i_clk = 0, i_rst = 1, i_lock_err_irq_en = 0, i_lock_err_clear = 0;
	logic i_erase_pin = 0, i_test_mode_pin = 0, i_port_line_0 = 0;
	logic i_port_line_1 = 0, i_port_line_2 = 0, i_debug_access = 0;
	logic i_fast_prog_access = 0, o_lock_error_flag, o_irq, o_debug_grant;
	logic o_fast_prog_grant, o_security, o_brownout_det_en, o_brownout_rst_en;
	logic o_fast_prog_mode, o_boot_recovery, flag_m = 0, sec_m = 0, seen_m = 0;
	logic [7:0] o_lock_bits, o_calib, lock_m = 0;
	logic [1:0] gp_m = 0;
	cmd_req_type i_cmd = '0;
	cmd_rsp_type o_rsp;
	cmd_type i_fast_prog_cmd = CMD_NONE;
	int err_total = 0, check_count = 0, cyc = 0, n;
	flash_protect #(.RECOVERY_CYC(20), .CALIB_VALUE(8'h3c)) dut (.*);
	always #2.5 i_clk = ~i_clk;
	// Hang guard far above the few hundred cycles the run needs
	always @(posedge i_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			err_total++;
			complete_run();
		end
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e)
		begin
			err_total++;
			$display("FAIL t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// Fast port takes everything but the general-bit commands
	function automatic logic fast_ok(input cmd_type c);
		return c != CMD_SET_GP && c != CMD_CLEAR_GP;
	endfunction
	task complete_run;
		$display("errors %0d checks %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// One command at a falling edge; outcome checked one cycle on.
	// Valid stays up into the next call so it is never written twice in one
	// time step; the caller drops it when a burst ends.
	task automatic cmd(input cmd_type c, input logic [7:0] p);
		logic ab, clr, wr;
		ab = ((c == CMD_PAGE_PROGRAM || c == CMD_PAGE_ERASE) && lock_m[p[7:5]])
			|| (c == CMD_FULL_ERASE && |lock_m);
		clr = 1'($urandom);
		wr = c == CMD_PAGE_PROGRAM || c == CMD_PAGE_ERASE ||
			c == CMD_FULL_ERASE;
		i_cmd = {1'b1, c, p};
		i_lock_err_clear = clr;
		i_debug_access = 1'($urandom);
		i_fast_prog_access = 1'($urandom);
		i_fast_prog_cmd = cmd_type'($urandom % 9);
		i_lock_err_irq_en = 1'($urandom);
		@(negedge i_clk);
		flag_m = ab | (flag_m & ~clr);
		if (!ab)
			case (c)
				CMD_SET_LOCK: lock_m[p[7:5]] = 1;
				CMD_CLEAR_LOCK: lock_m[p[7:5]] = 0;
				CMD_SET_SECURITY: sec_m = 1;
				CMD_FULL_ERASE: sec_m &= ~seen_m;
				CMD_SET_GP: gp_m[p[0]] = 1;
				CMD_CLEAR_GP: gp_m[p[0]] = 0;
				default: ;
			endcase
		chk({o_lock_bits, o_rsp.aborted, o_lock_error_flag, o_irq, o_security,
			o_brownout_rst_en, o_brownout_det_en, o_debug_grant,
			o_fast_prog_grant & sec_m}, {lock_m, ab, flag_m,
			flag_m & i_lock_err_irq_en, sec_m, gp_m, i_debug_access & ~sec_m,
			1'b0});
		// Every command is acknowledged; only unrefused writes proceed
		chk(16'({o_rsp.done, o_rsp.go}), 16'({1'b1, wr & ~ab}));
	endtask
	initial
	begin
		void'($urandom(64382));
		repeat (12) @(negedge i_clk);
		i_rst = 0;
		// Region boundary pages, back to back, then a random mix
		cmd(CMD_SET_LOCK, 8'h1f);
		cmd(CMD_PAGE_ERASE, 8'h20);
		cmd(CMD_PAGE_PROGRAM, 8'h00);
		cmd(CMD_SET_SECURITY, 8'h00);
		cmd(CMD_FULL_ERASE, 8'h00);
		repeat (150) cmd(cmd_type'(1 + $urandom % 8), 8'($urandom));
		i_cmd.valid = 0;
		i_lock_err_clear = 0;
		// Shortened stand-in for the long erase pin hold
		i_erase_pin = 1;
		repeat (5) @(negedge i_clk);
		i_erase_pin = 0;
		lock_m = 0;
		gp_m = 0;
		seen_m = 1;
		chk({o_lock_bits, o_calib}, 16'h003c);
		cmd(CMD_CLEAR_GP, 8'h00);
		cmd(CMD_FULL_ERASE, 8'h00);
		i_cmd.valid = 0;
		i_lock_err_clear = 0;
		i_fast_prog_access = 1;
		// Every strap combination twice, held past the synchroniser: first
		// with a general-bit command, then with a random allowed one
		for (n = 0; n < 32; n++)
		begin
			{i_test_mode_pin, i_port_line_0, i_port_line_1, i_port_line_2} = 4'(n);
			i_fast_prog_cmd = n[4] ? cmd_type'($urandom % 7) :
				cmd_type'(7 + n[0]);
			repeat (3) @(negedge i_clk);
			chk(16'({o_fast_prog_mode, o_fast_prog_grant}),
				16'({n[3:0] == 14, n[3:0] == 14 &&
				fast_ok(i_fast_prog_cmd) && !sec_m}));
		end
		// All straps stay high: exactly one recovery pulse expected
		n = 0;
		repeat (40)
		begin
			@(negedge i_clk);
			n += o_boot_recovery;
		end
		chk(16'(n), 16'h0001);
		complete_run();
	end
endmodule // test_flash_protect
bind flash_protect flash_protect_properties #(.CALIB_VALUE(CALIB_VALUE)) chk_i (
	.i_clk, .i_rst, .i_cmd, .o_rsp, .i_lock_err_irq_en, .i_erase_pin,
	.i_test_mode_pin, .i_port_line_0, .i_port_line_1, .i_port_line_2,
	.o_lock_error_flag, .o_irq, .o_debug_grant, .o_fast_prog_grant,
	.o_lock_bits, .o_security, .o_brownout_det_en, .o_brownout_rst_en,
	.o_calib, .o_fast_prog_mode, .o_boot_recovery
);
`default_nettype wire
